// file: kws_fall_det.sv
// Falling edge detector for a group of active-low inputs.
`timescale 1ns/1ps
module kws_fall_det #(
	parameter int unsigned W = 7
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Levels in, one-cycle edge pulses out
	input wire logic [W-1:0] i_lvl_n,
	output logic [W-1:0] o_fall
);
	logic [W-1:0] lvl_q;

	// Idle level is high, so a line that rests high gives no edge after reset.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			lvl_q <= {W{1'b1}};
		end else begin
			lvl_q <= i_lvl_n;
		end
	end

	assign o_fall = lvl_q & ~i_lvl_n;
endmodule

// file: kws_mac_model.sv
// Behavioural transmit MAC that answers keep-alive requests.
`timescale 1ns/1ps
module kws_mac_model #(
	parameter int unsigned DELAY = 4
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Request from the sequencer
	input wire logic i_req,
	input wire logic [10:0] i_base,
	// Collision fault armed by the bench for one base
	input wire logic i_arm,
	input wire logic [10:0] i_arm_base,
	// Completion back to the sequencer
	output logic o_done,
	output logic o_maxcol
);
	logic [7:0] wait_q;
	logic busy_q;
	logic col_q;
	logic junk_q;
	// Outside a completion the flag toggles, so it can never pass for valid.
	assign o_maxcol = o_done ? col_q : junk_q;
	always_ff @(posedge i_clk) begin
		junk_q <= ~junk_q;
		o_done <= 1'b0;
		if (!i_rst_n) begin
			busy_q <= 1'b0;
			wait_q <= 8'h00;
			col_q <= 1'b0;
			junk_q <= 1'b0;
		end else if (i_req) begin
			busy_q <= 1'b1;
			wait_q <= 8'(DELAY);
			col_q <= i_arm && (i_base == i_arm_base);
		end else if (busy_q) begin
			wait_q <= wait_q - 8'h01;
			if (wait_q == 8'h01) begin
				busy_q <= 1'b0;
				o_done <= 1'b1;
			end
		end
	end
endmodule

// file: kws_pkg.sv
// Shared constants and types for the keep-alive and wake sequencer.
package kws_pkg;
	// Clock rate and the one-second tick of the hidden interval timer.
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned TICK_SEC = 1;
	localparam int unsigned TICK_CYCLES = TICK_SEC * CLK_HZ;

	// Register byte offsets.
	localparam logic [7:0] REG_PWR = 8'h00;
	localparam logic [7:0] REG_EVT = 8'h04;
	localparam logic [7:0] REG_TRIG = 8'h08;
	localparam logic [7:0] REG_CMD = 8'h0c;
	localparam logic [7:0] REG_CTL = 8'h10;
	localparam logic [7:0] REG_STAT = 8'h14;
	localparam logic [7:0] REG_TMR = 8'h18;

	// power_control_reg fields.
	localparam int PWR_LVL_LSB = 0;
	localparam int PWR_WSE_BIT = 8;
	localparam int PWR_WSF_BIT = 15;
	localparam int PWR_PIN_BIT = 16;
	localparam logic [1:0] LVL_D0 = 2'h0;

	// wake_event_reg fields: enables low, sticky events high.
	localparam int EVT_EN_LSB = 0;
	localparam int EVT_HIT_LSB = 8;

	// Command and control fields.
	localparam int CMD_TXRST_BIT = 0;
	localparam int CMD_SPLIT_BIT = 1;
	localparam int CTL_BEN_BIT = 0;
	localparam int CTL_TXEN_BIT = 1;
	localparam int CTL_MASK_BIT = 2;

	// Status register fields.
	localparam int STAT_IDX_LSB = 8;
	localparam int STAT_SPLIT_BIT = 16;
	localparam int STAT_OFF_BIT = 17;
	localparam int STAT_PEND_BIT = 18;

	// frame_header_word fields of a keep-alive packet.
	localparam int HDR_PADDIS_BIT = 28;
	localparam int HDR_FINAL_BIT = 24;
	localparam int HDR_CDROP_BIT = 23;
	localparam int HDR_BND_MSB = 1;
	localparam int HDR_BND_LSB = 0;

	// Keep-alive control word fields.
	localparam int KC_ALERT_MSB = 31;
	localparam int KC_ALERT_LSB = 29;
	localparam int KC_GATE_BIT = 28;
	localparam int KC_TSEL_MSB = 27;
	localparam int KC_TSEL_LSB = 24;
	localparam int KC_INT_MSB = 15;
	localparam int KC_INT_LSB = 0;

	// alert_line_select codes for alert inputs 1 to 7.
	localparam logic [2:0] ALERT_OFF = 3'h0;
	localparam logic [2:0] ALERT_L1 = 3'h1;
	localparam logic [2:0] ALERT_L2 = 3'h3;
	localparam logic [2:0] ALERT_L3 = 3'h2;
	localparam logic [2:0] ALERT_L4 = 3'h4;
	localparam logic [2:0] ALERT_L5 = 3'h5;
	localparam logic [2:0] ALERT_L6 = 3'h6;
	localparam logic [2:0] ALERT_L7 = 3'h7;

	typedef enum logic [1:0] {ST_IDLE, ST_EVAL, ST_SEND} kws_state_t;
endpackage

// file: kws_sequencer.sv
// Keep-alive packet sequencer with wake event detection and signalling.
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
// How it works
// - Enabled wake event sets event, status, PME.
// - PCI reset rising edge returns to D0.
// - PME released when host clears signal enable.
// - Sleeping with enables, every received packet scanned.
// - Leftover patterns transmit once transmitter enabled.
// - Sleeping host: timer sends keep-alives periodically.
// - Pattern match sets matching trigger bit.
// - Keep-alives live in upper FIFO half.
// - Control word replaces second header dword.
// - Pad length to boundary unless disabled.
// - Collision-drop discards instead of disabling transmit.
// - Packet tag field ignored for keep-alives.
// - Alert select picks one falling alert input.
// - Host power gate: send only sleeping, powered.
// - Trigger select hits match trigger bits: send.
// - Keep scanning while powered down and enabled.
// - Send when hidden timer matches interval field.
// - Timer cleared on PCI reset, alert, reset, disable.
module kws_sequencer #(
	parameter int unsigned TICK_CYCLES = kws_pkg::TICK_CYCLES,
	parameter int unsigned KA_SLOTS = 8,
	parameter int unsigned ADDR_W = 11,
	parameter int unsigned LEN_W = 13
) (
	// Clock and reset
	input wire logic I_SYS_CLK,
	input wire logic I_RST_N,
	// Register port
	input wire logic [7:0] I_ADDR,
	input wire logic [31:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [31:0] O_RDATA,
	// Host power levels
	input wire logic I_PCI_RST_N,
	input wire logic I_SYS_SLEEP,
	input wire logic I_PCI_POWER,
	// Wake signal pin, open drain
	input wire logic I_PME_N,
	output logic O_PME_N,
	output logic O_PME_OE,
	// Receive classification from the matchers
	input wire logic I_RX_DONE,
	input wire logic [3:0] I_RX_WAKE_HIT,
	input wire logic [3:0] I_RX_PAT_HIT,
	// Alert inputs 1 to 7, active low
	input wire logic [6:0] I_ALERT_N,
	// Download into the transmit FIFO
	input wire logic I_DL_WORD,
	input wire logic I_KA_DESC,
	input wire logic [31:0] I_KA_HDR,
	input wire logic [31:0] I_KA_CTRL,
	input wire logic [LEN_W-1:0] I_KA_LEN,
	output logic [ADDR_W-1:0] O_DL_ADDR,
	output logic O_DESC_READY,
	// Transmit requests to the MAC
	output logic O_TX_REQ,
	output logic [ADDR_W-1:0] O_TX_BASE,
	output logic [LEN_W-1:0] O_TX_LEN,
	output logic O_TX_DROP,
	input wire logic I_TX_DONE,
	input wire logic I_TX_MAXCOL,
	output logic O_NORMAL_TX_GO
);
	localparam int IDX_W = $clog2(KA_SLOTS);
	localparam int PTR_W = ADDR_W - 1;

	logic [1:0] lvl_q;
	logic wse_q, wsf_q, prst_q;
	logic [3:0] evt_en_q, evt_q, trig_q;
	logic ben_q, txen_q, fmask_q, split_q, tx_off_q, pat_pend_q;
	logic [PTR_W-1:0] norm_ptr_q, ka_ptr_q;
	logic [IDX_W:0] cnt_q;
	logic [31:0] tick_cnt_q;
	logic [15:0] timer_q, act_time_q;
	kws_pkg::kws_state_t state_q;
	logic [IDX_W-1:0] idx_q;
	logic pend_tick_q, act_tick_q;
	logic [3:0] pend_trig_q, act_trig_q;
	logic [6:0] pend_alert_q, act_alert_q;
	logic [31:0] rdata_q;
	logic tx_req_q, tx_drop_q;
	logic [ADDR_W-1:0] tx_base_q;
	logic [LEN_W-1:0] tx_len_q;
	logic [31:0] hdr_q [KA_SLOTS];
	logic [31:0] ctl_q [KA_SLOTS];
	logic [LEN_W-1:0] len_q [KA_SLOTS];
	logic [PTR_W-1:0] base_q [KA_SLOTS];

	function automatic logic [2:0] alert_line(input logic [2:0] sel);
		case (sel)
			kws_pkg::ALERT_L1: alert_line = 3'h0;
			kws_pkg::ALERT_L2: alert_line = 3'h1;
			kws_pkg::ALERT_L3: alert_line = 3'h2;
			kws_pkg::ALERT_L4: alert_line = 3'h3;
			kws_pkg::ALERT_L5: alert_line = 3'h4;
			kws_pkg::ALERT_L6: alert_line = 3'h5;
			kws_pkg::ALERT_L7: alert_line = 3'h6;
			default: alert_line = 3'h0;
		endcase
	endfunction

	// Register decode.
	wire wr_pwr = I_WR && I_ADDR == kws_pkg::REG_PWR;
	wire wr_evt = I_WR && I_ADDR == kws_pkg::REG_EVT;
	wire wr_trig = I_WR && I_ADDR == kws_pkg::REG_TRIG;
	wire wr_cmd = I_WR && I_ADDR == kws_pkg::REG_CMD;
	wire wr_ctl = I_WR && I_ADDR == kws_pkg::REG_CTL;
	wire cmd_txrst = wr_cmd && I_WDATA[kws_pkg::CMD_TXRST_BIT];
	wire cmd_split = wr_cmd && I_WDATA[kws_pkg::CMD_SPLIT_BIT];
	wire [3:0] evt_clr = wr_evt ? I_WDATA[kws_pkg::EVT_HIT_LSB +: 4] : 4'h0;
	wire [3:0] trig_clr = wr_trig ? I_WDATA[3:0] : 4'h0;
	wire wsf_clr = wr_pwr && I_WDATA[kws_pkg::PWR_WSF_BIT];

	// Wake scanning and pattern triggers.
	wire pci_rise = I_PCI_RST_N && !prst_q;
	wire asleep = lvl_q != kws_pkg::LVL_D0;
	wire scan = asleep && |evt_en_q;
	wire [3:0] wake_hit = {4{I_RX_DONE && scan}} & evt_en_q & I_RX_WAKE_HIT;
	wire [3:0] pat_set = {4{I_RX_DONE && asleep}} & I_RX_PAT_HIT;

	// Hidden interval timer.
	wire [6:0] alert_fall;
	wire tick = tick_cnt_q == 32'(TICK_CYCLES - 1);
	wire timer_clr = pci_rise || |alert_fall || (cmd_txrst && !fmask_q)
		|| !ben_q;

	// Stored packet under evaluation.
	wire [31:0] cur_hdr = hdr_q[idx_q];
	wire [31:0] cur_ctl = ctl_q[idx_q];
	wire [15:0] cur_int = cur_ctl[kws_pkg::KC_INT_MSB:kws_pkg::KC_INT_LSB];
	wire [3:0] cur_tsel = cur_ctl[kws_pkg::KC_TSEL_MSB:kws_pkg::KC_TSEL_LSB];
	wire [2:0] cur_alert = cur_ctl[kws_pkg::KC_ALERT_MSB:kws_pkg::KC_ALERT_LSB];
	wire in_range = {1'b0, idx_q} < cnt_q;
	wire last = cur_hdr[kws_pkg::HDR_FINAL_BIT]
		|| {1'b0, idx_q} == cnt_q - 1'b1;
	// One-bit intervals make this a match every interval seconds.
	wire due_time = act_tick_q && cur_int != 16'h0
		&& (act_time_q & (cur_int - 16'h1)) == 16'h0;
	wire due_trig = |(cur_tsel & act_trig_q);
	wire due_alert = cur_alert != kws_pkg::ALERT_OFF
		&& act_alert_q[alert_line(cur_alert)];
	wire gate_ok = !cur_ctl[kws_pkg::KC_GATE_BIT]
		|| (I_SYS_SLEEP && I_PCI_POWER);
	wire fire = (due_time || due_trig || due_alert) && gate_ok && !tx_off_q;
	wire eval_fire = state_q == kws_pkg::ST_EVAL && in_range && fire;
	wire walk_go = state_q == kws_pkg::ST_IDLE && asleep && ben_q
		&& (pend_tick_q || |pend_trig_q || |pend_alert_q);

	// Length padding; the tag field is never looked at.
	wire [1:0] cur_bnd = cur_hdr[kws_pkg::HDR_BND_MSB:kws_pkg::HDR_BND_LSB];
	wire [3:0] pad_m4 = 4'hf >> (2'h3 - cur_bnd);
	wire [LEN_W-1:0] pad_m = LEN_W'(pad_m4);
	wire [LEN_W-1:0] cur_len = len_q[idx_q];
	wire [LEN_W-1:0] pad_len = (cur_len + pad_m) & ~pad_m;
	wire cur_drop = cur_hdr[kws_pkg::HDR_CDROP_BIT];
	wire send_done = state_q == kws_pkg::ST_SEND && I_TX_DONE;

	// Read mux.
	wire [31:0] rd_pwr = {15'h0, !I_PME_N, wsf_q, 6'h0, wse_q, 6'h0, lvl_q};
	wire [31:0] rd_evt = {20'h0, evt_q, 4'h0, evt_en_q};
	wire [31:0] rd_stat = {13'h0, pat_pend_q, tx_off_q, split_q, 4'h0,
		4'(idx_q), 3'h0, 5'(cnt_q)};
	wire [31:0] rd_val =
		I_ADDR == kws_pkg::REG_PWR ? rd_pwr :
		I_ADDR == kws_pkg::REG_EVT ? rd_evt :
		I_ADDR == kws_pkg::REG_TRIG ? {28'h0, trig_q} :
		I_ADDR == kws_pkg::REG_CTL ? {29'h0, fmask_q, txen_q, ben_q} :
		I_ADDR == kws_pkg::REG_STAT ? rd_stat :
		I_ADDR == kws_pkg::REG_TMR ? {16'h0, timer_q} : 32'h0;

	kws_fall_det #(.W(7)) u_alert (
		.i_clk(I_SYS_CLK),
		.i_rst_n(I_RST_N),
		.i_lvl_n(I_ALERT_N),
		.o_fall(alert_fall)
	);

	// Power control and wake events; a set always beats a clear.
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RST_N) begin
			lvl_q <= kws_pkg::LVL_D0;
			wse_q <= 1'b0;
			wsf_q <= 1'b0;
			evt_en_q <= 4'h0;
			evt_q <= 4'h0;
			trig_q <= 4'h0;
			prst_q <= 1'b1;
		end else begin
			prst_q <= I_PCI_RST_N;
			// Enable and status survive PCI reset so the host can find them.
			if (pci_rise) begin
				lvl_q <= kws_pkg::LVL_D0;
			end else if (wr_pwr) begin
				lvl_q <= I_WDATA[kws_pkg::PWR_LVL_LSB +: 2];
			end
			if (wr_pwr) begin
				wse_q <= I_WDATA[kws_pkg::PWR_WSE_BIT];
			end
			wsf_q <= (wsf_q && !wsf_clr) || |wake_hit;
			evt_q <= (evt_q & ~evt_clr) | wake_hit;
			if (wr_evt) begin
				evt_en_q <= I_WDATA[kws_pkg::EVT_EN_LSB +: 4];
			end
			trig_q <= (trig_q & ~trig_clr) | pat_set;
		end
	end

	// Control bits, FIFO split and download pointers.
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RST_N) begin
			ben_q <= 1'b0;
			txen_q <= 1'b0;
			fmask_q <= 1'b0;
			split_q <= 1'b0;
			pat_pend_q <= 1'b0;
			norm_ptr_q <= '0;
			ka_ptr_q <= '0;
			cnt_q <= '0;
		end else begin
			if (wr_ctl) begin
				ben_q <= I_WDATA[kws_pkg::CTL_BEN_BIT];
				txen_q <= I_WDATA[kws_pkg::CTL_TXEN_BIT];
				fmask_q <= I_WDATA[kws_pkg::CTL_MASK_BIT];
			end
			if (cmd_split) begin
				split_q <= 1'b1;
				ka_ptr_q <= '0;
				cnt_q <= '0;
			end else if (I_DL_WORD && split_q) begin
				ka_ptr_q <= ka_ptr_q + 1'b1;
			end else if (I_KA_DESC && O_DESC_READY) begin
				cnt_q <= cnt_q + 1'b1;
			end
			// Purging the normal area is the only way to clear the pending patterns.
			if (cmd_txrst) begin
				norm_ptr_q <= '0;
			end else if (I_DL_WORD && !split_q) begin
				norm_ptr_q <= norm_ptr_q + 1'b1;
			end
			pat_pend_q <= (pat_pend_q && !cmd_txrst)
				|| (I_DL_WORD && !split_q);
		end
	end

	// Descriptor store; plain storage, so no reset is needed.
	always_ff @(posedge I_SYS_CLK) begin
		if (I_KA_DESC && O_DESC_READY && !cmd_split && !I_DL_WORD) begin
			hdr_q[cnt_q[IDX_W-1:0]] <= I_KA_HDR;
			ctl_q[cnt_q[IDX_W-1:0]] <= I_KA_CTRL;
			len_q[cnt_q[IDX_W-1:0]] <= I_KA_LEN;
			base_q[cnt_q[IDX_W-1:0]] <= ka_ptr_q;
		end
	end

	// One-second prescaler and hidden interval timer.
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RST_N || timer_clr) begin
			tick_cnt_q <= 32'h0;
			timer_q <= 16'h0;
		end else if (tick) begin
			tick_cnt_q <= 32'h0;
			timer_q <= timer_q + 16'h1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h1;
		end
	end

	// Trigger events wait here until a walk takes them over.
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RST_N) begin
			pend_tick_q <= 1'b0;
			pend_trig_q <= 4'h0;
			pend_alert_q <= 7'h0;
			act_tick_q <= 1'b0;
			act_trig_q <= 4'h0;
			act_alert_q <= 7'h0;
			act_time_q <= 16'h0;
		end else begin
			// A timer restart drops a tick that no walk has taken yet.
			pend_tick_q <= ((pend_tick_q && !walk_go) || tick) && !timer_clr;
			pend_trig_q <= (walk_go ? 4'h0 : pend_trig_q) | (pat_set & ~trig_q);
			pend_alert_q <= (walk_go ? 7'h0 : pend_alert_q) | alert_fall;
			if (walk_go) begin
				act_tick_q <= pend_tick_q;
				act_trig_q <= pend_trig_q;
				act_alert_q <= pend_alert_q;
				act_time_q <= timer_q;
			end
		end
	end

	// Walk the stored packets in order.
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RST_N) begin
			state_q <= kws_pkg::ST_IDLE;
			idx_q <= '0;
		end else begin
			case (state_q)
				kws_pkg::ST_IDLE: begin
					idx_q <= '0;
					if (walk_go) begin
						state_q <= kws_pkg::ST_EVAL;
					end
				end
				kws_pkg::ST_EVAL: begin
					if (!in_range) begin
						state_q <= kws_pkg::ST_IDLE;
					end else if (fire) begin
						state_q <= kws_pkg::ST_SEND;
					end else if (last) begin
						state_q <= kws_pkg::ST_IDLE;
					end else begin
						idx_q <= idx_q + 1'b1;
					end
				end
				kws_pkg::ST_SEND: begin
					if (I_TX_DONE) begin
						state_q <= last ? kws_pkg::ST_IDLE : kws_pkg::ST_EVAL;
						idx_q <= last ? idx_q : idx_q + 1'b1;
					end
				end
				default: state_q <= kws_pkg::ST_IDLE;
			endcase
		end
	end

	// Transmit request and the transmit-path disable on max collisions.
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RST_N) begin
			tx_req_q <= 1'b0;
			tx_base_q <= '0;
			tx_len_q <= '0;
			tx_drop_q <= 1'b0;
			tx_off_q <= 1'b0;
		end else begin
			tx_req_q <= eval_fire;
			if (eval_fire) begin
				tx_base_q <= {1'b1, base_q[idx_q]};
				tx_len_q <= cur_hdr[kws_pkg::HDR_PADDIS_BIT] ? cur_len : pad_len;
				tx_drop_q <= cur_drop;
			end
			if (send_done && I_TX_MAXCOL && !cur_drop) begin
				tx_off_q <= 1'b1;
			end else if (cmd_txrst) begin
				tx_off_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RST_N) begin
			rdata_q <= 32'h0;
		end else begin
			rdata_q <= I_RD ? rd_val : 32'h0;
		end
	end

	assign O_RDATA = rdata_q;
	assign O_PME_N = 1'b0;
	assign O_PME_OE = wsf_q && wse_q;
	assign O_DL_ADDR = split_q ? {1'b1, ka_ptr_q} : {1'b0, norm_ptr_q};
	assign O_DESC_READY = split_q && cnt_q < (IDX_W + 1)'(KA_SLOTS);
	assign O_TX_REQ = tx_req_q;
	assign O_TX_BASE = tx_base_q;
	assign O_TX_LEN = tx_len_q;
	assign O_TX_DROP = tx_drop_q;
	assign O_NORMAL_TX_GO = txen_q && pat_pend_q && !tx_off_q;

	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_RST_N);

	wake_set_a: assert property (
		|wake_hit && wse_q && !wr_pwr |=> wsf_q && O_PME_OE && (|evt_q))
		else $error("wake hit did not set status and PME");
	d0_return_a: assert property (
		pci_rise |=> lvl_q == kws_pkg::LVL_D0)
		else $error("PCI reset release did not return to D0");
	pme_release_a: assert property (
		wr_pwr && !I_WDATA[kws_pkg::PWR_WSE_BIT] |=> !O_PME_OE)
		else $error("PME stayed asserted after enable cleared");
	trig_set_a: assert property (
		I_RX_DONE && asleep && I_RX_PAT_HIT[0] |=> trig_q[0])
		else $error("pattern match did not set trigger bit");
	upper_half_a: assert property (
		O_TX_REQ |-> O_TX_BASE[ADDR_W-1])
		else $error("keep-alive request outside upper FIFO half");
	drop_keep_a: assert property (
		send_done && I_TX_MAXCOL && cur_drop && !tx_off_q && !cmd_txrst
		|=> !tx_off_q)
		else $error("collision drop packet disabled transmit path");
	power_gate_a: assert property (
		state_q == kws_pkg::ST_EVAL && in_range
		&& cur_ctl[kws_pkg::KC_GATE_BIT] && !(I_SYS_SLEEP && I_PCI_POWER)
		|=> !O_TX_REQ)
		else $error("gated packet sent without sleep and power");
	timer_clear_a: assert property (
		!ben_q ##1 !ben_q |-> timer_q == 16'h0 && !pend_tick_q)
		else $error("interval timer ran while beacons disabled");
endmodule

// file: tb_top.sv
// Self-checking bench for the keep-alive and wake sequencer.
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd_s = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic pci_rst_n = 1'b1, sleep = 1'b1, pci_pwr = 1'b1;
	logic pme_n, pme_oe, pme_wire;
	logic rx_done = 1'b0;
	logic [3:0] wake_hit = 4'h0, pat_hit = 4'h0;
	logic [6:0] alert_n = 7'h7f;
	logic dl_word = 1'b0, ka_desc = 1'b0;
	logic [31:0] ka_hdr = 32'h0, ka_ctrl = 32'h0;
	logic [12:0] ka_len = 13'h0, tx_len, len0, len1;
	logic [10:0] dl_addr, tx_base, arm_base = 11'h000;
	logic desc_rdy, tx_req, tx_drop, tx_done, tx_maxcol, norm_go, drop0;
	logic arm = 1'b0;
	int errors = 0, compares = 0, cnt0 = 0, cnt1 = 0, cnt2 = 0, c, k;
	int cyc = 0, last1 = 0, prev1 = 0;
	always #10 clk = ~clk;
	// Open-drain wake pin with its pull-up.
	assign pme_wire = pme_oe ? pme_n : 1'b1;
	kws_sequencer #(.TICK_CYCLES(20)) kws_sequencer_i (
		.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
		.I_WR(wr), .I_RD(rd_s), .O_RDATA(rdata), .I_PCI_RST_N(pci_rst_n),
		.I_SYS_SLEEP(sleep), .I_PCI_POWER(pci_pwr), .I_PME_N(pme_wire),
		.O_PME_N(pme_n), .O_PME_OE(pme_oe), .I_RX_DONE(rx_done),
		.I_RX_WAKE_HIT(wake_hit), .I_RX_PAT_HIT(pat_hit),
		.I_ALERT_N(alert_n), .I_DL_WORD(dl_word), .I_KA_DESC(ka_desc),
		.I_KA_HDR(ka_hdr), .I_KA_CTRL(ka_ctrl), .I_KA_LEN(ka_len),
		.O_DL_ADDR(dl_addr), .O_DESC_READY(desc_rdy), .O_TX_REQ(tx_req),
		.O_TX_BASE(tx_base), .O_TX_LEN(tx_len), .O_TX_DROP(tx_drop),
		.I_TX_DONE(tx_done), .I_TX_MAXCOL(tx_maxcol),
		.O_NORMAL_TX_GO(norm_go));
	kws_mac_model kws_mac_model_i (.i_clk(clk), .i_rst_n(rst_n),
		.i_req(tx_req), .i_base(tx_base), .i_arm(arm),
		.i_arm_base(arm_base), .o_done(tx_done), .o_maxcol(tx_maxcol));
	// Request monitor, keyed by the slot base address.
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (tx_req === 1'b1) begin
			if (tx_base === 11'h400) begin
				cnt0 = cnt0 + 1;
				len0 = tx_len;
				drop0 = tx_drop;
			end else if (tx_base === 11'h404) begin
				cnt1 = cnt1 + 1;
				prev1 = last1;
				last1 = cyc;
				len1 = tx_len;
			end else begin
				cnt2 = cnt2 + 1;
			end
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares = compares + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		@(posedge clk);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 chk(rdata & m, exp);
	endtask
	task automatic rx(input logic [3:0] w, input logic [3:0] p);
		@(posedge clk);
		rx_done <= 1'b1;
		wake_hit <= w;
		pat_hit <= p;
		@(posedge clk);
		rx_done <= 1'b0;
		#1;
	endtask
	// One descriptor followed by four payload words.
	task automatic desc(input logic [31:0] h, input logic [31:0] cw);
		@(posedge clk);
		ka_desc <= 1'b1;
		ka_hdr <= h;
		ka_ctrl <= cw;
		ka_len <= 13'h03d;
		@(posedge clk);
		ka_desc <= 1'b0;
		dl_word <= 1'b1;
		repeat (4) @(posedge clk);
		dl_word <= 1'b0;
	endtask
	task automatic tally_and_finish;
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		errors = errors + 1;
		tally_and_finish;
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd_chk(8'h14, 32'hffffffff, 32'h0);
		rd_chk(8'h00, 32'hffffffff, 32'h0);
		rd_chk(8'h20, 32'hffffffff, 32'h0);
		// Leftover words in the normal area go out once enabled.
		@(posedge clk);
		dl_word <= 1'b1;
		repeat (2) @(posedge clk);
		dl_word <= 1'b0;
		wr_reg(8'h10, 32'h2);
		chk(norm_go, 1'b1);
		wr_reg(8'h0c, 32'h1);
		chk(norm_go, 1'b0);
		wr_reg(8'h10, 32'h0);
		wr_reg(8'h0c, 32'h2);
		chk(dl_addr, 11'h400);
		chk(desc_rdy, 1'b1);
		desc(32'h008003fd, 32'h02000000);
		desc(32'h11000003, 32'h70000002);
		desc(32'h00000000, 32'h02000001);
		rd_chk(8'h14, 32'h0003001f, 32'h00010003);
		// Wake with one class enabled and a second class hit but masked.
		wr_reg(8'h04, 32'h1);
		wr_reg(8'h00, 32'h103);
		rx(4'h3, 4'h0);
		chk(pme_oe, 1'b1);
		rd_chk(8'h00, 32'hffffffff, 32'h00018103);
		rd_chk(8'h04, 32'hffffffff, 32'h00000101);
		wr_reg(8'h00, 32'h003);
		chk(pme_oe, 1'b0);
		@(posedge clk);
		pci_rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		pci_rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd_chk(8'h00, 32'hffffffff, 32'h00008000);
		wr_reg(8'h00, 32'h8003);
		wr_reg(8'h04, 32'h100);
		// Periodic sends of slot one, two ticks apart.
		wr_reg(8'h10, 32'h1);
		c = cnt1;
		for (k = 0; k < 300 && cnt1 < c + 2; k++) @(posedge clk);
		chk(last1 - prev1, 32'd40);
		chk(cnt1 - c, 32'd2);
		chk(len1, 13'h03d);
		// The power gate holds slot one back while awake, then unpowered.
		@(posedge clk);
		sleep <= 1'b0;
		c = cnt1;
		repeat (50) @(posedge clk);
		sleep <= 1'b1;
		pci_pwr <= 1'b0;
		repeat (50) @(posedge clk);
		chk(cnt1 - c, 32'd0);
		pci_pwr <= 1'b1;
		// Pattern trigger sends slot zero, whose collision is discarded.
		arm <= 1'b1;
		arm_base <= 11'h400;
		c = cnt0;
		rx(4'h0, 4'h2);
		for (k = 0; k < 100 && cnt0 == c; k++) @(posedge clk);
		chk(cnt0 - c, 32'd1);
		chk(len0, 13'h040);
		chk(drop0, 1'b1);
		rd_chk(8'h08, 32'hffffffff, 32'h2);
		wr_reg(8'h08, 32'h2);
		repeat (8) @(posedge clk);
		rd_chk(8'h14, 32'h00020000, 32'h0);
		// Only the selected alert line sends slot one.
		arm_base <= 11'h404;
		c = cnt1;
		alert_n <= 7'h7e;
		repeat (8) @(posedge clk);
		chk(cnt1 - c, 32'd0);
		alert_n <= 7'h7c;
		for (k = 0; k < 12 && cnt1 == c; k++) @(posedge clk);
		chk(cnt1 - c, 32'd1);
		arm <= 1'b0;
		alert_n <= 7'h7f;
		repeat (8) @(posedge clk);
		rd_chk(8'h14, 32'h00020000, 32'h00020000);
		wr_reg(8'h0c, 32'h1);
		rd_chk(8'h14, 32'h00020000, 32'h0);
		wr_reg(8'h10, 32'h0);
		rd_chk(8'h18, 32'h0000ffff, 32'h0);
		chk(cnt2, 32'd0);
		tally_and_finish;
	end
endmodule
